// ==== cmp_ctrl_pkg.sv ====
// Package: register map, field layout, reset values and types for the comparator control
package cmp_ctrl_pkg;
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] FLAG_OFFSET = 4'h4;
    localparam logic [3:0] PORT_OFFSET = 4'h8;
    localparam logic [3:0] DIR_OFFSET = 4'hC;
    localparam int CMP2_RESULT_BIT = 7;
    localparam int CMP1_RESULT_BIT = 6;
    localparam int CMP2_POLARITY_BIT = 5;
    localparam int CMP1_POLARITY_BIT = 4;
    localparam int INPUT_SWITCH_BIT = 3;
    localparam int MODE_MSB = 2;
    localparam int FLAG_BIT = 0;
    localparam int CHANGE_ENABLE_BIT = 1;
    localparam int PERIPH_ENABLE_BIT = 2;
    localparam int GLOBAL_ENABLE_BIT = 3;
    localparam logic [5:0] CTRL_RESET = 6'h07;
    localparam logic [5:0] DIR_RESET = 6'h3F;
    localparam logic [2:0] MODE_INTREF = 3'h6;
    localparam logic [2:0] MODE_OFF = 3'h7;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        MODE0, MODE1, MODE2, MODE3, MODE4, MODE5, MODE_REF, MODE_COMPOFF
    } cmp_mode_t;

    // Routing decided by the mode decoder
    typedef struct packed {
        logic [3:0] analogPins;
        logic cmp1On;
        logic cmp2On;
        logic outPinsOn;
        logic intRefPlus;
        logic [1:0] cmp1MinusSel;
        logic [1:0] cmp2MinusSel;
    } route_t;
endpackage

// ==== cmp_sync.sv ====
// Two-stage synchroniser for one comparator output
`timescale 1ns/1ps
module cmp_sync
    import cmp_ctrl_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic asyncIn,
    output logic syncOut
);
    logic [STAGES-1:0] chain_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = chain_reg[STAGES-1];
endmodule

// ==== cmp_mode_decode.sv ====
// Mode decoder: comparator input and output routing for each mode code
`timescale 1ns/1ps
module cmp_mode_decode
    import cmp_ctrl_pkg::*;
#(
    parameter logic [3:0] ANALOG_MAP [0:5] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h3, 4'hB},
    parameter logic [5:0] OUTPIN_MAP = 6'h20
) (
    input wire logic [2:0] mode,
    input wire logic inputSwitch,
    output route_t route
);
    always_comb begin
        route = '0;
        route.cmp1MinusSel = 2'h0;
        route.cmp2MinusSel = 2'h1;
        case (cmp_mode_t'(mode))
            MODE_REF: begin
                route.analogPins = 4'hF;
                route.cmp1On = 1'b1;
                route.cmp2On = 1'b1;
                route.intRefPlus = 1'b1;
                route.cmp1MinusSel = inputSwitch ? 2'h3 : 2'h0;
                route.cmp2MinusSel = inputSwitch ? 2'h2 : 2'h1;
            end
            MODE_COMPOFF: begin
                route.analogPins = 4'h0;
            end
            default: begin
                route.analogPins = ANALOG_MAP[mode];
                route.cmp1On = 1'b1;
                route.cmp2On = 1'b1;
                route.outPinsOn = OUTPIN_MAP[mode];
            end
        endcase
    end
endmodule

// ==== dual_comparator_control.sv ====
// Comparator control: register slave, polarity, change flag, pin multiplexers
//
// Notes on behaviour
// - Bit 7 shows comparator 2 result, bit 6 comparator 1; writes ignore them.
// - Bits 5 and 4 invert comparator 2 and 1 results when set.
// - Bit 3 in mode 110 moves inverting inputs to pins A3/A2, else A0/A1.
// - Low three bits select one of eight routing modes.
// - Mode 110 feeds the internal reference to both non-inverting inputs.
// - Output mode 101 drives pins A4/A5 straight from comparators, unclocked.
// - Port direction bits still enable the A4/A5 outputs in that mode.
// - Port reads return 0 on pins that the mode makes analog.
// - Any change of either comparator output sets the change flag.
// - Writing 0 clears the flag; writing 1 sets it.
// - Request needs change, peripheral and global enables; flag sets regardless.
// - Mismatch keeps setting flag until a control register access latches outputs.
// - A change coinciding with a control read may be missed.
// - Comparators and change wake-up keep working in sleep.
// - Wake from sleep leaves the control register untouched.
// - Reset gives mode 111 and clears polarity and input switch.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dual_comparator_control
    import cmp_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic cmp1Raw,
    input wire logic cmp2Raw,
    input wire logic [5:0] portPinIn,
    input wire logic [5:0] portLatch,
    output logic [5:0] portPinOut,
    output logic [5:0] portPinOe,
    output route_t route,
    output logic irqRequest,
    output logic wakeRequest
);
    logic [5:0] ctrl_reg;
    logic [5:0] dir_reg;
    logic flag_reg;
    logic changeEnable_reg;
    logic periphEnable_reg;
    logic globalEnable_reg;
    logic [1:0] seen_reg;
    logic answered_reg;
    logic [31:0] readdata_reg;
    logic cmp1Sync;
    logic cmp2Sync;
    logic [1:0] result;
    logic [1:0] rawResult;
    logic mismatch;
    logic access;
    logic ctrlAccess;
    logic flagWrite;
    logic [31:0] readdata_next;
    logic [5:0] portView;

    cmp_sync u_sync1 (
        .core_clk(core_clk),
        .reset(reset),
        .asyncIn(cmp1Raw),
        .syncOut(cmp1Sync)
    );

    cmp_sync u_sync2 (
        .core_clk(core_clk),
        .reset(reset),
        .asyncIn(cmp2Raw),
        .syncOut(cmp2Sync)
    );

    cmp_mode_decode u_decode (
        .mode(ctrl_reg[MODE_MSB:0]),
        .inputSwitch(ctrl_reg[INPUT_SWITCH_BIT]),
        .route(route)
    );

    // Clocked results with polarity; off comparators read 0
    assign result[1] = route.cmp2On & (cmp2Sync ^ ctrl_reg[CMP2_POLARITY_BIT]);
    assign result[0] = route.cmp1On & (cmp1Sync ^ ctrl_reg[CMP1_POLARITY_BIT]);
    // Unclocked copies for the pin multiplexers
    assign rawResult[1] = cmp2Raw ^ ctrl_reg[CMP2_POLARITY_BIT];
    assign rawResult[0] = cmp1Raw ^ ctrl_reg[CMP1_POLARITY_BIT];

    // Bus handshake: one wait cycle, answer on the second edge
    assign access = (read | write) & ~answered_reg;
    assign waitrequest = (read | write) & ~answered_reg;
    assign ctrlAccess = (read | write) & answered_reg & (address == CTRL_OFFSET);
    assign flagWrite = write & answered_reg & (address == FLAG_OFFSET);
    assign readdata = readdata_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            answered_reg <= 1'b0;
        end else begin
            answered_reg <= access;
        end
    end

    // Control register; sleep has no path here so wake-up keeps it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
        end else if (write & answered_reg & (address == CTRL_OFFSET)) begin
            ctrl_reg <= writedata[5:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dir_reg <= DIR_RESET;
        end else if (write & answered_reg & (address == DIR_OFFSET)) begin
            dir_reg <= writedata[5:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            changeEnable_reg <= 1'b0;
            periphEnable_reg <= 1'b0;
            globalEnable_reg <= 1'b0;
        end else if (flagWrite) begin
            changeEnable_reg <= writedata[CHANGE_ENABLE_BIT];
            periphEnable_reg <= writedata[PERIPH_ENABLE_BIT];
            globalEnable_reg <= writedata[GLOBAL_ENABLE_BIT];
        end
    end

    // Latched copy of results, refreshed on every control access
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seen_reg <= 2'h0;
        end else if (ctrlAccess) begin
            seen_reg <= result;
        end
    end

    assign mismatch = (result != seen_reg);

    // Change flag: hardware set wins over a software clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flag_reg <= 1'b0;
        end else if (mismatch & ~ctrlAccess) begin
            flag_reg <= 1'b1;
        end else if (flagWrite) begin
            flag_reg <= writedata[FLAG_BIT];
        end
    end

    assign irqRequest = flag_reg & changeEnable_reg & periphEnable_reg
        & globalEnable_reg;
    // Wake-up needs only the local enable; sleep does not stop this logic
    assign wakeRequest = flag_reg & changeEnable_reg;

    // Port view: analog pins read as zero
    assign portView = portPinIn & ~{2'b00, route.analogPins};

    always_comb begin
        readdata_next = 32'h0000_0000;
        case (address)
            CTRL_OFFSET: readdata_next = {24'h0, result, ctrl_reg};
            FLAG_OFFSET: readdata_next = {28'h0, globalEnable_reg, periphEnable_reg,
                changeEnable_reg, flag_reg};
            PORT_OFFSET: readdata_next = {26'h0, portView};
            DIR_OFFSET: readdata_next = {26'h0, dir_reg};
            default: readdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            readdata_reg <= 32'h0000_0000;
        end else if (access & read) begin
            readdata_reg <= readdata_next;
        end
    end

    // Pin multiplexers: A4/A5 take raw comparator outputs in output mode 101
    always_comb begin
        portPinOut = portLatch;
        if (route.outPinsOn) begin
            portPinOut[4] = rawResult[0];
            portPinOut[5] = rawResult[1];
        end
        portPinOe = ~dir_reg;
    end

    a_bus_answer: assert property (@(posedge core_clk) disable iff (reset) // bus
        (read | write) & waitrequest |=> !waitrequest)
        else $error("Bus request not answered in one wait cycle");
    a_result_ro: assert property (@(posedge core_clk) disable iff (reset)
        ctrlAccess & write |=> ctrl_reg == $past(writedata[5:0]))
        else $error("Control write did not store writable bits");
    a_polarity_inv: assert property (@(posedge core_clk) disable iff (reset)
        route.cmp1On |-> result[0] == (cmp1Sync ^ ctrl_reg[CMP1_POLARITY_BIT]))
        else $error("Comparator 1 polarity wrong");
    a_switch_route: assert property (@(posedge core_clk) disable iff (reset)
        ctrl_reg[2:0] == MODE_INTREF && ctrl_reg[INPUT_SWITCH_BIT]
        |-> route.cmp1MinusSel == 2'h3 && route.cmp2MinusSel == 2'h2)
        else $error("Input switch routing wrong");
    a_ref_route: assert property (@(posedge core_clk) disable iff (reset)
        route.intRefPlus == (ctrl_reg[2:0] == MODE_INTREF))
        else $error("Reference routing wrong");
    a_flag_set: assert property (@(posedge core_clk) disable iff (reset)
        mismatch & ~ctrlAccess |=> flag_reg)
        else $error("Change did not set flag");
    a_flag_clear: assert property (@(posedge core_clk) disable iff (reset)
        flagWrite & ~writedata[FLAG_BIT] & ~mismatch ##1 ~mismatch |-> ~flag_reg)
        else $error("Flag clear failed");
    a_irq_gate: assert property (@(posedge core_clk) disable iff (reset)
        irqRequest |-> flag_reg && globalEnable_reg && periphEnable_reg)
        else $error("Interrupt without all enables");
    a_port_analog: assert property (@(posedge core_clk) disable iff (reset)
        read & answered_reg ##0 (address == PORT_OFFSET) |=>
        (readdata[3:0] & route.analogPins) == 4'h0)
        else $error("Analog pin read nonzero");
    a_off_reset: assert property (@(posedge core_clk)
        $fell(reset) |-> ctrl_reg[2:0] == MODE_OFF && ctrl_reg[5:3] == 3'h0)
        else $error("Reset state wrong");

    c_flag_rise: cover property (@(posedge core_clk) disable iff (reset) $rose(flag_reg));
    c_irq: cover property (@(posedge core_clk) disable iff (reset) irqRequest);
    c_ref_mode: cover property (@(posedge core_clk) disable iff (reset) route.intRefPlus);
    c_ctrl_read: cover property (@(posedge core_clk) disable iff (reset) ctrlAccess & read);
endmodule

// ==== cmp_far_side.sv ====
// Far-side model: two comparators and the port A pins
`timescale 1ns/1ps
module cmp_far_side
    import cmp_ctrl_pkg::*;
#(
    parameter int RESP_NS = 3
) (
    input wire route_t route,
    input wire logic [5:0] portPinOut,
    input wire logic [5:0] portPinOe,
    input wire logic [5:0] extLevel,
    input wire logic plus1Hi,
    input wire logic plus2Hi,
    output logic cmp1Raw,
    output logic cmp2Raw,
    output logic [5:0] portPinIn
);
    // A powered-down comparator output sits low
    assign #(RESP_NS) cmp1Raw = route.cmp1On & plus1Hi;
    assign #(RESP_NS) cmp2Raw = route.cmp2On & plus2Hi;
    // Pin A4 is open collector: it only pulls low against the pull-up
    always_comb begin
        portPinIn = extLevel;
        for (int i = 0; i < 6; i++) begin
            if (portPinOe[i]) begin
                portPinIn[i] = (i == 4) ? (portPinOut[i] & extLevel[i]) : portPinOut[i];
            end
        end
    end
endmodule

// ==== dual_comparator_control_tb.sv ====
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module dual_comparator_control_tb
    import cmp_ctrl_pkg::*;
;
    localparam logic [3:0] AMAP [0:5] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h3, 4'hB};
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [5:0] portLatch = 6'h00;
    logic [5:0] extLevel = 6'h3F;
    logic plus1Hi = 1'b0;
    logic plus2Hi = 1'b0;
    logic [31:0] readdata, q;
    logic waitrequest, cmp1Raw, cmp2Raw, irqRequest, wakeRequest;
    logic [5:0] portPinIn, portPinOut, portPinOe, cfg;
    route_t route;
    int errors = 0;
    int checks = 0;
    int seed;
    always #20 core_clk = ~core_clk;
    dual_comparator_control DUT (.core_clk(core_clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cmp1Raw(cmp1Raw), .cmp2Raw(cmp2Raw),
        .portPinIn(portPinIn), .portLatch(portLatch), .portPinOut(portPinOut),
        .portPinOe(portPinOe), .route(route), .irqRequest(irqRequest),
        .wakeRequest(wakeRequest));
    cmp_far_side far (.route(route), .portPinOut(portPinOut), .portPinOe(portPinOe),
        .extLevel(extLevel), .plus1Hi(plus1Hi), .plus2Hi(plus2Hi), .cmp1Raw(cmp1Raw),
        .cmp2Raw(cmp2Raw), .portPinIn(portPinIn));
    task end_of_test();
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        // Hold the request until waitrequest is sampled low at a rising edge
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            chk(32'(waitrequest), 32'h0);
            end_of_test();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
    endtask
    function automatic logic [31:0] expCtrl(input logic [5:0] c, input logic h1, input logic h2);
        logic on;
        on = (c[2:0] == MODE_INTREF);
        return {24'h0, on & (h2 ^ c[5]), on & (h1 ^ c[4]), c};
    endfunction
    initial begin
        seed = $urandom(32'h80607856);
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        bus(0, CTRL_OFFSET, 0);
        chk(q, 32'h07);
        bus(0, DIR_OFFSET, 0);
        chk(q, 32'(DIR_RESET));
        bus(1, 4'h2, 32'hFF);
        bus(0, 4'h2, 0);
        chk(q, 32'h0);
        bus(1, CTRL_OFFSET, 32'hFF);
        bus(0, CTRL_OFFSET, 0);
        chk(q, 32'h3F);
        for (int m = 0; m < 6; m++) begin
            bus(1, CTRL_OFFSET, 32'(m));
            extLevel <= 6'($urandom);
            chk(32'(route.analogPins), 32'(AMAP[m]));
            chk(32'(route.outPinsOn), 32'(m == 5));
            bus(0, PORT_OFFSET, 0);
            chk(q, 32'(extLevel & ~{2'b00, AMAP[m]}));
        end
        repeat (12) begin
            cfg = (6'($urandom) & 6'h38) | 6'h06;
            plus1Hi <= 1'($urandom);
            plus2Hi <= 1'($urandom);
            bus(1, CTRL_OFFSET, 32'(cfg));
            repeat (6) @(posedge core_clk);
            bus(0, CTRL_OFFSET, 0);
            chk(q, expCtrl(cfg, plus1Hi, plus2Hi));
            chk(32'(route.intRefPlus), 32'h1);
            chk(32'({route.cmp1MinusSel, route.cmp2MinusSel}), cfg[3] ? 32'hE : 32'h1);
        end
        plus1Hi <= 1'b0;
        plus2Hi <= 1'b0;
        bus(1, CTRL_OFFSET, 32'h06);
        repeat (6) @(posedge core_clk);
        bus(0, CTRL_OFFSET, 0);
        bus(1, FLAG_OFFSET, 0);
        bus(0, FLAG_OFFSET, 0);
        chk(q, 32'h0);
        plus1Hi <= 1'b1;
        repeat (6) @(posedge core_clk);
        bus(0, FLAG_OFFSET, 0);
        chk(q, 32'h1);
        bus(1, FLAG_OFFSET, 0);
        bus(0, FLAG_OFFSET, 0);
        chk(q, 32'h1);
        bus(0, CTRL_OFFSET, 0);
        bus(1, FLAG_OFFSET, 0);
        bus(0, FLAG_OFFSET, 0);
        chk(q, 32'h0);
        for (int i = 0; i < 8; i++) begin
            bus(1, FLAG_OFFSET, 32'({3'(i), 1'b1}));
            bus(0, FLAG_OFFSET, 0);
            chk(q, 32'({3'(i), 1'b1}));
            chk(32'(irqRequest), 32'(i == 7));
            chk(32'(wakeRequest), 32'(i % 2));
        end
        bus(1, FLAG_OFFSET, 32'hE);
        chk(32'(irqRequest), 32'h0);
        bus(1, CTRL_OFFSET, 32'h05);
        bus(1, DIR_OFFSET, 32'h2A);
        chk(32'(portPinOe), 32'h15);
        bus(1, DIR_OFFSET, 0);
        portLatch <= 6'($urandom);
        plus1Hi <= 1'($urandom);
        plus2Hi <= 1'($urandom);
        repeat (2) @(posedge core_clk);
        chk(32'(portPinOut), 32'({plus2Hi, plus1Hi, portLatch[3:0]}));
        plus2Hi <= ~plus2Hi;
        @(negedge core_clk);
        chk(32'(portPinOut[5:4]), 32'({plus2Hi, plus1Hi}));
        @(posedge core_clk);
        bus(1, CTRL_OFFSET, 32'h07);
        bus(1, CTRL_OFFSET, 32'h3E);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        bus(0, CTRL_OFFSET, 0);
        chk(q, 32'h07);
        end_of_test();
    end
endmodule
